// >>> shared/uib_pkg.sv
// Shared constants and carriers for the serial port interrupt/baud block.
// Assumes an APB master with 32-bit data; one register per aligned word.
package uib_pkg;
   // Printed offsets are not multiples of four: index, byte address = 4*idx
   localparam logic [2:0] IDX_DATA  = 3'h0; // rx/tx buffer, divisor low
   localparam logic [2:0] IDX_IEN   = 3'h1; // interrupt enable, divisor high
   localparam logic [2:0] IDX_CAUSE = 3'h2; // cause read, fifo control write
   localparam logic [2:0] IDX_LCTL  = 3'h3;
   localparam logic [2:0] IDX_MCTL  = 3'h4;
   localparam logic [2:0] IDX_LSR   = 3'h5;
   localparam logic [2:0] IDX_MSR   = 3'h6;
   localparam logic [2:0] IDX_LAST  = 3'h6;
   // Enable bits
   localparam int IE_RX    = 0;
   localparam int IE_THRE  = 1;
   localparam int IE_LINE  = 2;
   localparam int IE_MODEM = 3;
   localparam int IE_TC    = 4;
   // Line control / fifo control fields
   localparam int LC_DLAB  = 7;
   localparam int FC_EN    = 0;
   localparam int FC_TRG_LO = 6;
   // Line status fields
   localparam int LS_DR    = 0;
   localparam int LS_OE    = 1;
   localparam int LS_PE    = 2;
   localparam int LS_FE    = 3;
   localparam int LS_BI    = 4;
   localparam int LS_THRE  = 5;
   localparam int LS_TEMT  = 6;
   localparam int LS_ERR   = 7;
   // Cause codes
   localparam logic [2:0] CS_NONE  = 3'h1;
   localparam logic [2:0] CS_LINE  = 3'h6;
   localparam logic [2:0] CS_RXRDY = 3'h4;
   localparam logic [2:0] CS_TOUT  = 3'h5;
   localparam logic [2:0] CS_THRE  = 3'h2;
   localparam logic [2:0] CS_TC    = 3'h3;
   localparam logic [2:0] CS_MODEM = 3'h0;
   // Reset values
   localparam logic [15:0] DIV_RST   = 16'h0002;
   localparam logic [15:0] DIV_ONE   = 16'h0001;
   localparam logic [7:0]  LCTL_RST  = 8'h00;
   // Timing
   localparam logic [3:0]  OVERSAMPLE = 4'hf;   // 16 ticks per bit, minus 1
   localparam logic [2:0]  TOUT_BYTES = 3'h4;   // byte times before time-out
   localparam logic [3:0]  BYTE_BITS  = 4'ha;   // bits counted per byte time

   typedef struct packed {
      logic       err;
      logic [3:0] flags; // bi fe pe oe
      logic [7:0] data;
   } uib_rxent_type;

   typedef struct packed {
      logic [15:0] cnt;
   } uib_baud_type;
endpackage : uib_pkg

// >>> logic/uib_baud.sv
// Baud divider: down-counter producing a 16x tick.
// Assumes divisor and load strobe from the register block on the same clock.
`timescale 1ns/100ps
module uib_baud
   import uib_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        clk_en_in,
   // Divisor
   input  wire logic [15:0] divisor_in,
   input  wire logic        load_in,
   // Tick
   output logic             tick_out
);
   uib_baud_type st_ff, nxt_st;
   logic         tick_ff, nxt_tick;

   always_comb begin
      nxt_st   = st_ff;
      nxt_tick = 1'b0;
      if (load_in) begin
         nxt_st.cnt = divisor_in;
      end else if (st_ff.cnt <= DIV_ONE) begin
         nxt_st.cnt = divisor_in;
         nxt_tick   = 1'b1;
      end else begin
         nxt_st.cnt = st_ff.cnt - 16'h0001;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_ff   <= '{cnt: DIV_RST};
         tick_ff <= 1'b0;
      end else if (clk_en_in) begin
         st_ff   <= nxt_st;
         tick_ff <= nxt_tick;
      end
   end
   assign tick_out = tick_ff;

   AST_RELOAD_PULSE: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      (clk_en_in && !load_in && st_ff.cnt == DIV_ONE) |=> tick_ff)
      else $error("baud tick missing after count of one");
   AST_RESTART: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      (clk_en_in && load_in) |=> (st_ff.cnt == $past(divisor_in) && !tick_ff))
      else $error("divisor write did not restart count");
endmodule : uib_baud

// >>> logic/uib_rxfifo.sv
// Receive FIFO storage with registered head read data.
// Assumes caller never writes when full or reads when empty.
`timescale 1ns/100ps
module uib_rxfifo
   import uib_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int AW    = 4
)(
   // Clock and reset
   input  wire logic          core_clk_in,
   input  wire logic          rst_n_in,
   input  wire logic          clk_en_in,
   // Ports
   input  wire logic          wr_in,
   input  wire uib_rxent_type wdata_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [AW-1:0] raddr_in,
   output uib_rxent_type      rdata_out,
   output logic [DEPTH-1:0]   err_map_out
);
   uib_rxent_type mem_ff [DEPTH];
   uib_rxent_type rd_ff;
   logic [DEPTH-1:0] errv_ff;

   always_ff @(posedge core_clk_in) begin
      if (clk_en_in && wr_in) begin
         mem_ff[waddr_in] <= wdata_in;
      end
   end
   // Error bits in flops so the whole FIFO can be scanned, and flushed
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         errv_ff <= '0;
         rd_ff   <= '0;
      end else if (clk_en_in) begin
         if (wr_in) begin
            errv_ff[waddr_in] <= wdata_in.err;
         end
         rd_ff <= (wr_in && waddr_in == raddr_in) ? wdata_in
                                                  : mem_ff[raddr_in];
      end
   end
   assign rdata_out   = rd_ff;
   assign err_map_out = errv_ff;
endmodule : uib_rxfifo

// >>> logic/uib_core.sv
// Serial port interrupt logic and register file on APB.
// Assumes receiver/transmitter shift logic outside, same clock.
// Contract
// - Six interrupt causes from tx, rx, modem
// - Holding-empty interrupt while holding buffer empty
// - Tx-complete interrupt; holding write clears both
// - FIFO mode: ready when count reaches trigger
// - Non-FIFO mode: ready when byte held
// - Time-out after four idle byte times
// - Ready and time-out share one enable
// - Line interrupt on parity, framing, overrun, break
// - Line status read clears line interrupt
// - FIFO mode: line interrupt when error at head
// - Error flag while any error byte stored
// - Modem input change interrupts; status read clears
// - Reset restores defaults and flushes FIFOs
// - Enabling tx interrupt when empty fires at once
// - Receiver always enabled, no enable control
// - Divider counts down, reloads, pulses at one
// - Divisor resets to two; write restarts count
// - Divisor reachable only with line control bit 7
// - One tx bit per sixteen baud ticks
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/100ps
module uib_core
   import uib_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int AW    = 4
)(
   // Clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        clk_en_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [31:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Receiver byte in
   input  wire logic        rx_valid_in,
   input  wire logic [7:0]  rx_data_in,
   input  wire logic [3:0]  rx_flags_in,
   // Transmitter side
   input  wire logic        tx_take_in,
   input  wire logic        tx_shift_done_in,
   output logic [7:0]       tx_data_out,
   output logic             tx_full_out,
   output logic             tx_bit_step_out,
   // Modem pins
   input  wire logic [3:0]  modem_pins_in,
   output logic [1:0]       modem_ctl_out,
   // Interrupt request, baud tick, line control
   output logic             irq_out,
   output logic             baud_tick_out,
   output logic [6:0]       line_ctl_out
);
   localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);
   typedef struct packed {
      logic [7:0]  lctl;
      logic [7:0]  fctl;
      logic [4:0]  ien;
      logic [1:0]  mctl;
      logic [15:0] divisor;
      logic [7:0]  thr;
      logic        thr_full;
      logic        tc;
      logic        line_pend;
      logic [3:0]  modem_delta;
      logic [3:0]  pin_s1;
      logic [3:0]  pin_s2;
      logic [3:0]  pin_old;
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [AW:0] count;
      logic        tout;
      logic [3:0]  tick16;
      logic [3:0]  txdiv;
      logic [3:0]  bitcnt;
      logic [2:0]  bytecnt;
      logic [31:0] rdata;
   } uib_core_type;

   uib_core_type  st_ff, nxt;
   uib_rxent_type head;
   logic [DEPTH-1:0] err_map;
   logic        wr_acc, rd_acc, dlab, fifo_on, rx_pop, rx_push;
   logic        div_load, tick, thr_wr, lsr_rd, msr_rd, rbr_rd;
   logic [2:0]  idx;
   logic [AW:0] trig;
   logic        rx_ready, line_irq, thre_irq, tc_irq;
   logic [2:0]  cause;
   uib_rxent_type push_ent;
   logic [DEPTH-1:0] err_live;

   assign idx     = paddr_in[4:2];
   assign wr_acc  = psel_in && penable_in && pwrite_in;
   assign rd_acc  = psel_in && penable_in && !pwrite_in;
   assign dlab    = st_ff.lctl[LC_DLAB];
   assign fifo_on = st_ff.fctl[FC_EN];
   // Divisor only behind bit 7 of line control
   assign div_load = wr_acc && dlab && (idx == IDX_DATA || idx == IDX_IEN);
   assign thr_wr   = wr_acc && !dlab && idx == IDX_DATA;
   assign rbr_rd   = rd_acc && !dlab && idx == IDX_DATA;
   assign lsr_rd   = rd_acc && idx == IDX_LSR;
   assign msr_rd   = rd_acc && idx == IDX_MSR;
   assign rx_pop   = rbr_rd && st_ff.count != '0;
   assign rx_push  = rx_valid_in &&
                     (st_ff.count < (fifo_on ? DEPTH_W : (AW+1)'(1)));
   assign push_ent = '{err: |rx_flags_in, flags: rx_flags_in,
                       data: rx_data_in};

   always_comb begin
      case (st_ff.fctl[7:FC_TRG_LO])
         2'h0:    trig = (AW+1)'(1);
         2'h1:    trig = (AW+1)'(4);
         2'h2:    trig = (AW+1)'(8);
         2'h3:    trig = (AW+1)'(14);
         default: trig = (AW+1)'(1);
      endcase
   end

   // Stale error bits of popped entries must not hold the summary flag
   always_comb begin
      for (int n = 0; n < DEPTH; n++) begin
         err_live[n] = err_map[n] &&
            ({1'b0, AW'(AW'(n) - st_ff.rptr)} < st_ff.count);
      end
   end

   // Receive ready: trigger in FIFO mode, one byte otherwise
   assign rx_ready = fifo_on ? (st_ff.count >= trig)
                             : (st_ff.count != '0);
   // Head error only: errors deeper in the FIFO wait their turn
   assign line_irq = st_ff.line_pend && st_ff.count != '0 &&
                     head.err;
   assign thre_irq = !st_ff.thr_full;
   assign tc_irq   = st_ff.tc;

   // Priority: line, rx, time-out, tx empty, tx complete, modem
   always_comb begin
      cause = CS_NONE;
      if (st_ff.ien[IE_LINE] && line_irq)               cause = CS_LINE;
      else if (st_ff.ien[IE_RX] && rx_ready)            cause = CS_RXRDY;
      else if (st_ff.ien[IE_RX] && st_ff.tout)          cause = CS_TOUT;
      else if (st_ff.ien[IE_THRE] && thre_irq)          cause = CS_THRE;
      else if (st_ff.ien[IE_TC] && tc_irq)              cause = CS_TC;
      else if (st_ff.ien[IE_MODEM] && |st_ff.modem_delta) cause = CS_MODEM;
   end

   always_comb begin
      nxt = st_ff;
      // Pin synchroniser; stage one feeds only stage two
      nxt.pin_s1  = modem_pins_in;
      nxt.pin_s2  = st_ff.pin_s1;
      nxt.pin_old = st_ff.pin_s2;
      // Register writes
      if (wr_acc) begin
         case (idx)
            IDX_DATA:  if (dlab) nxt.divisor[7:0] = pwdata_in[7:0];
                       else      nxt.thr = pwdata_in[7:0];
            IDX_IEN:   if (dlab) nxt.divisor[15:8] = pwdata_in[7:0];
                       else      nxt.ien = pwdata_in[4:0];
            IDX_CAUSE: nxt.fctl = pwdata_in[7:0];
            IDX_LCTL:  nxt.lctl = pwdata_in[7:0];
            IDX_MCTL:  nxt.mctl = pwdata_in[1:0];
            default:   nxt.lctl = st_ff.lctl;
         endcase
      end
      // Holding buffer: write fills, transmitter take empties
      if (thr_wr) begin
         nxt.thr_full = 1'b1;
         nxt.tc       = 1'b0;
      end else if (tx_take_in) begin
         nxt.thr_full = 1'b0;
      end
      if (tx_shift_done_in && !st_ff.thr_full && !thr_wr) begin
         nxt.tc = 1'b1;
      end
      // Receive FIFO pointers; receiver has no enable
      if (rx_push) nxt.wptr = st_ff.wptr + AW'(1);
      if (rx_pop)  nxt.rptr = st_ff.rptr + AW'(1);
      nxt.count = st_ff.count + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
      if (wr_acc && idx == IDX_CAUSE && pwdata_in[FC_EN] != fifo_on) begin
         nxt.wptr  = '0;
         nxt.rptr  = '0;
         nxt.count = '0;
      end
      // Line interrupt: new head error sets, status read clears
      if (rx_pop || (rx_push && st_ff.count == '0)) begin
         nxt.line_pend = 1'b1;
      end else if (lsr_rd) begin
         nxt.line_pend = 1'b0;
      end
      // Modem change detect; a change wins over the clearing read
      if (msr_rd) nxt.modem_delta = '0;
      nxt.modem_delta = nxt.modem_delta |
                        (st_ff.pin_s2 ^ st_ff.pin_old);
      // Free-running bit divider, apart from the time-out timer
      if (tick) nxt.txdiv = st_ff.txdiv + 4'h1;
      // Byte-time timer for the receive time-out
      if (rx_push || rx_pop) begin
         nxt.tick16  = '0;
         nxt.bitcnt  = '0;
         nxt.bytecnt = '0;
      end else if (tick && st_ff.count != '0 && st_ff.count < trig &&
                   st_ff.bytecnt != TOUT_BYTES) begin
         nxt.tick16 = st_ff.tick16 + 4'h1;
         if (st_ff.tick16 == OVERSAMPLE) begin
            nxt.bitcnt = st_ff.bitcnt + 4'h1;
            if (st_ff.bitcnt == BYTE_BITS - 4'h1) begin
               nxt.bitcnt  = '0;
               nxt.bytecnt = st_ff.bytecnt + 3'h1;
            end
         end
      end
      if (nxt.count == '0) begin
         nxt.tout = 1'b0;
      end else if (st_ff.bytecnt == TOUT_BYTES && st_ff.count != '0) begin
         nxt.tout = 1'b1;
      end
      // Read data
      nxt.rdata = '0;
      if (psel_in && !penable_in && !pwrite_in) begin
         case (idx)
            IDX_DATA:  nxt.rdata[7:0] = dlab ? st_ff.divisor[7:0]
                                             : head.data;
            IDX_IEN:   nxt.rdata[7:0] = dlab ? st_ff.divisor[15:8]
                                             : {3'h0, st_ff.ien};
            IDX_CAUSE: nxt.rdata[7:0] = {fifo_on, fifo_on, 3'h0, cause};
            IDX_LCTL:  nxt.rdata[7:0] = st_ff.lctl;
            IDX_MCTL:  nxt.rdata[7:0] = {6'h0, st_ff.mctl};
            IDX_LSR:   nxt.rdata[7:0] = {|err_live,
                          !st_ff.thr_full && st_ff.tc, !st_ff.thr_full,
                          (st_ff.count != '0) ? head.flags : 4'h0,
                          st_ff.count != '0};
            IDX_MSR:   nxt.rdata[7:0] = {st_ff.pin_s2, st_ff.modem_delta};
            default:   nxt.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_ff         <= '0;
         st_ff.lctl    <= LCTL_RST;
         st_ff.divisor <= DIV_RST;
      end else if (clk_en_in) begin
         st_ff <= nxt;
      end
   end

   uib_baud u_baud (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .clk_en_in   (clk_en_in),
      .divisor_in  (nxt.divisor),
      .load_in     (div_load),
      .tick_out    (tick)
   );

   uib_rxfifo #(.DEPTH(DEPTH), .AW(AW)) u_fifo (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .clk_en_in   (clk_en_in),
      .wr_in       (rx_push),
      .wdata_in    (push_ent),
      .waddr_in    (st_ff.wptr),
      .raddr_in    (nxt.rptr),
      .rdata_out   (head),
      .err_map_out (err_map)
   );

   // Interrupt line follows the cause, rx pair on one enable
   assign irq_out         = (cause != CS_NONE);
   assign pready_out      = 1'b1;
   assign pslverr_out     = psel_in && penable_in && (idx > IDX_LAST);
   assign prdata_out      = st_ff.rdata;
   assign tx_data_out     = st_ff.thr;
   assign tx_full_out     = st_ff.thr_full;
   assign tx_bit_step_out = tick && st_ff.txdiv == OVERSAMPLE;
   assign baud_tick_out   = tick;
   assign modem_ctl_out   = st_ff.mctl;
   assign line_ctl_out    = st_ff.lctl[6:0];

   AST_THRE_NOW: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      (clk_en_in && wr_acc && idx == IDX_IEN && !dlab &&
       pwdata_in[IE_THRE] && !st_ff.thr_full && !tx_take_in)
      |=> (cause != CS_NONE))
      else $error("tx empty interrupt not raised at enable");
   AST_THR_CLEAR: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      (clk_en_in && thr_wr) |=> (st_ff.thr_full && !st_ff.tc))
      else $error("holding write did not clear tx interrupts");
   AST_LSR_CLEAR: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      (clk_en_in && lsr_rd && !rx_pop && !rx_push) |=> !line_irq)
      else $error("line status read did not clear interrupt");
   AST_TOUT_CLEAR: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      (st_ff.tout && st_ff.count != '0 && !(clk_en_in && rx_pop &&
       st_ff.count == (AW+1)'(1))) |=> st_ff.tout)
      else $error("time-out dropped before FIFO empty");
   AST_DLAB_GATE: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      (clk_en_in && wr_acc && !dlab) |=> $stable(st_ff.divisor))
      else $error("divisor changed without access bit");
   AST_RX_READY: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      (!fifo_on && st_ff.count != '0 && st_ff.ien[IE_RX] &&
       !line_irq) |-> irq_out)
      else $error("single-byte ready not signalled");
   AST_MODEM_CHG: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      (clk_en_in && (st_ff.pin_s2 != st_ff.pin_old)) |=>
      (|st_ff.modem_delta))
      else $error("modem change lost");
   AST_ERR_FLAG: assert property (@(posedge core_clk_in)
      disable iff (!rst_n_in)
      (clk_en_in && rx_push && push_ent.err) |=> ##1 (|err_map))
      else $error("error byte not flagged");
endmodule : uib_core

// >>> dv/uib_peer.sv
// Far-side model: serial peer behind the rx and tx shifters.
// Assumes bit steps from the core; one byte time is ten bit steps.
`timescale 1ns/100ps
module uib_peer
   import uib_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // From core
   input  wire logic       step_in,
   input  wire logic       full_in,
   // Bench request
   input  wire logic       send_in,
   input  wire logic [7:0] byte_in,
   input  wire logic [3:0] flags_in,
   // To core
   output logic            rx_valid_out,
   output logic [7:0]      rx_data_out,
   output logic [3:0]      rx_flags_out,
   output logic            take_out,
   output logic            done_out
);
   logic [3:0] rcnt_ff;
   logic [3:0] tcnt_ff;
   logic       rbusy_ff;
   logic       tbusy_ff;
   logic [7:0] byte_ff;
   logic [3:0] flg_ff;
   // Idle lines show the inverse, so a stale byte never looks valid
   assign rx_data_out  = rx_valid_out ? byte_ff : ~byte_ff;
   assign rx_flags_out = rx_valid_out ? flg_ff : ~flg_ff;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         {rcnt_ff, tcnt_ff, rbusy_ff, tbusy_ff, byte_ff, flg_ff} <= '0;
         {rx_valid_out, take_out, done_out} <= '0;
      end else begin
         rx_valid_out <= 1'b0;
         take_out     <= 1'b0;
         done_out     <= 1'b0;
         if (send_in) begin
            {rbusy_ff, rcnt_ff} <= {1'b1, 4'h0};
            {byte_ff, flg_ff}   <= {byte_in, flags_in};
         end else if (rbusy_ff && step_in) begin
            rcnt_ff <= rcnt_ff + 4'h1;
            if (rcnt_ff == 4'h9) begin
               rbusy_ff     <= 1'b0;
               rx_valid_out <= 1'b1;
            end
         end
         if (!tbusy_ff && full_in && step_in) begin
            {tbusy_ff, tcnt_ff, take_out} <= {1'b1, 4'h0, 1'b1};
         end else if (tbusy_ff && step_in) begin
            tcnt_ff <= tcnt_ff + 4'h1;
            if (tcnt_ff == 4'h9) begin
               tbusy_ff <= 1'b0;
               done_out <= 1'b1;
            end
         end
      end
   end
endmodule : uib_peer

// >>> dv/uib_core_tb.sv
// Self-checking bench for the interrupt and baud core over APB.
// Assumes zero-wait APB slave and the peer model on the byte side.
`timescale 1ns/100ps
module uib_core_tb
   import uib_pkg::*;
();
   logic        clk, rst_n, psel, pen, pwr, send, se;
   logic        pready, rxv, take, done, full, step, tick, irq;
   logic [31:0] paddr, pwdata, prdata, rd, x;
   logic [7:0]  sbyte, b, txd, rxd;
   logic [3:0]  sflg, pins, rxf;
   logic [6:0]  lc;
   logic [1:0]  mc;
   int          err_total, n_checks, i, d;
   always #12.5 clk = ~clk;
   uib_core uib_core_i (.core_clk_in(clk), .rst_n_in(rst_n),
      .clk_en_in(1'b1), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(se),
      .rx_valid_in(rxv), .rx_data_in(rxd), .rx_flags_in(rxf),
      .tx_take_in(take), .tx_shift_done_in(done), .tx_data_out(txd),
      .tx_full_out(full), .tx_bit_step_out(step),
      .modem_pins_in(pins), .modem_ctl_out(mc), .irq_out(irq),
      .baud_tick_out(tick), .line_ctl_out(lc));
   uib_peer uib_peer_i (.clk_in(clk), .rst_n_in(rst_n), .step_in(step),
      .full_in(full), .send_in(send), .byte_in(sbyte), .flags_in(sflg),
      .rx_valid_out(rxv), .rx_data_out(rxd), .rx_flags_out(rxf),
      .take_out(take), .done_out(done));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   function automatic logic [31:0] cv(input logic f, input logic [2:0] c);
      return {24'h0, f, f, 3'h0, c};
   endfunction : cv
   task test_done;
      if (err_total == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   task ck(input logic [31:0] e, input logic [31:0] g, input string nm);
      n_checks++;
      if (g !== e) begin
         $display("unexpected %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask : ck
   task apb(input logic w, input logic [2:0] a, input logic [7:0] wd);
      int k;
      @(posedge clk);
      {psel, pen, pwr} <= {1'b1, 1'b0, w};
      paddr  <= {27'h0, a, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      pen <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 16) begin
         err_total++;
         test_done();
      end
      rd = prdata;
      {psel, pen} <= 2'b00;
   endtask : apb
   task wr(input logic [2:0] a, input logic [7:0] v);
      apb(1'b1, a, v);
   endtask : wr
   task rc(input logic [2:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 8'h00);
      ck(e, rd, nm);
   endtask : rc
   task ci(input logic e);
      @(negedge clk);
      ck({31'h0, e}, {31'h0, irq}, "irq");
   endtask : ci
   // Bounded wait on irq (k=0) or a delivered byte (k=1)
   task wt(input int k);
      int j;
      for (j = 0; j < 3000; j++) begin
         @(negedge clk);
         if ((k == 1 ? rxv : irq) === 1'b1) break;
      end
      if (j == 3000) begin
         err_total++;
         test_done();
      end
   endtask : wt
   task snd(input logic [7:0] v, input logic [3:0] f);
      @(posedge clk);
      {send, sbyte, sflg} <= {1'b1, v, f};
      @(posedge clk);
      send <= 1'b0;
      wt(1);
   endtask : snd
   // Clocks between two pulses of the baud tick or the bit step
   task tp(input logic bs, input int e);
      int n;
      for (n = 0; n < 2000; n++) begin
         @(negedge clk);
         if ((bs ? step : tick) === 1'b1) break;
      end
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while ((bs ? step : tick) !== 1'b1 && n < 2000);
      ck(e, n, "period");
   endtask : tp
   task sdiv(input logic [15:0] dv);
      wr(IDX_LCTL, 8'h80);
      wr(IDX_IEN, dv[15:8]);
      wr(IDX_DATA, dv[7:0]);
      wr(IDX_LCTL, 8'h00);
   endtask : sdiv
   initial begin
      {clk, rst_n, psel, pen, pwr, send, paddr, pwdata} = '0;
      {sbyte, sflg, pins, err_total, n_checks} = '0;
      x = 32'h4b7cb1d0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rc(IDX_LCTL, 32'h0, "lctl");
      rc(IDX_IEN, 32'h0, "ien");
      rc(IDX_LSR, 32'h20, "lsr");
      ci(1'b0);
      wr(IDX_IEN, 8'h08);
      wr(IDX_LCTL, 8'h80);
      rc(IDX_DATA, {24'h0, DIV_RST[7:0]}, "div_lo");
      rc(IDX_IEN, {24'h0, DIV_RST[15:8]}, "div_hi");
      wr(IDX_LCTL, 8'h00);
      rc(IDX_IEN, 32'h08, "ien");
      tp(1'b0, 2);
      tp(1'b1, 32);
      for (i = 0; i < 3; i++) begin
         x = xs(x);
         d = (i == 2) ? 1 : 3 + x[2:0];
         sdiv(16'(d));
         tp(1'b0, d);
      end
      wr(IDX_IEN, 8'h01 << IE_THRE);
      ci(1'b1);
      rc(IDX_CAUSE, cv(1'b0, CS_THRE), "cause");
      x = xs(x);
      b = x[7:0];
      wr(IDX_DATA, b);
      ci(1'b0);
      ck({24'h0, b}, {24'h0, txd}, "tx_data");
      wr(IDX_IEN, 8'h01 << IE_TC);
      wt(0);
      rc(IDX_CAUSE, cv(1'b0, CS_TC), "cause");
      wr(IDX_DATA, ~b);
      ci(1'b0);
      wr(IDX_IEN, 8'h01 << IE_RX);
      x = xs(x);
      snd(x[7:0], 4'h0);
      wt(0);
      rc(IDX_CAUSE, cv(1'b0, CS_RXRDY), "cause");
      apb(1'b0, IDX_LSR, 8'h00);
      ck(32'h1, 32'(rd[LS_DR]), "ready");
      rc(IDX_DATA, {24'h0, x[7:0]}, "rx");
      ci(1'b0);
      wr(IDX_IEN, 8'h01 << IE_LINE);
      for (i = 0; i < 4; i++) begin
         x = xs(x);
         snd(x[7:0], 4'h1 << i);
         wt(0);
         apb(1'b0, IDX_LSR, 8'h00);
         ck(32'h1, 32'(rd[LS_OE + i]), "lsr_err");
         ci(1'b0);
         apb(1'b0, IDX_DATA, 8'h00);
      end
      wr(IDX_CAUSE, 8'h01);
      wr(IDX_IEN, 8'h01 << IE_RX);
      snd(8'h5a, 4'h0);
      wt(0);
      rc(IDX_CAUSE, cv(1'b1, CS_RXRDY), "cause");
      rc(IDX_DATA, 32'h5a, "rx");
      ci(1'b0);
      wr(IDX_CAUSE, 8'h41);
      snd(8'h11, 4'h0);
      snd(8'h22, 4'h0);
      wt(0);
      rc(IDX_CAUSE, cv(1'b1, CS_TOUT), "cause");
      rc(IDX_DATA, 32'h11, "rx");
      ci(1'b1);
      rc(IDX_DATA, 32'h22, "rx");
      ci(1'b0);
      wr(IDX_IEN, 8'h01 << IE_LINE);
      snd(8'h33, 4'h0);
      snd(8'h44, 4'h2);
      ci(1'b0);
      apb(1'b0, IDX_LSR, 8'h00);
      ck(32'h1, 32'(rd[LS_ERR]), "err_flag");
      rc(IDX_DATA, 32'h33, "rx");
      wt(0);
      rc(IDX_CAUSE, cv(1'b1, CS_LINE), "cause");
      apb(1'b0, IDX_LSR, 8'h00);
      ck(32'h1, 32'(rd[LS_PE]), "lsr_err");
      ci(1'b0);
      rc(IDX_DATA, 32'h44, "rx");
      apb(1'b0, IDX_LSR, 8'h00);
      ck(32'h0, 32'(rd[LS_ERR]), "err_flag");
      wr(IDX_IEN, 8'h01 << IE_MODEM);
      x = xs(x);
      pins <= x[3:0] | 4'h1;
      wt(0);
      rc(IDX_CAUSE, cv(1'b1, CS_MODEM), "cause");
      apb(1'b0, IDX_MSR, 8'h00);
      ck({28'h0, pins}, {28'h0, rd[7:4]}, "modem");
      ci(1'b0);
      apb(1'b0, 3'h7, 8'h00);
      ck(32'h1, {31'h0, se}, "slverr");
      ck(32'h0, rd, "unmapped");
      wr(IDX_LCTL, 8'h83);
      wr(IDX_MCTL, 8'h02);
      @(negedge clk);
      ck(32'h03, {25'h0, lc}, "line_ctl");
      ck(32'h02, {30'h0, mc}, "modem_ctl");
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rc(IDX_LCTL, 32'h0, "lctl");
      rc(IDX_IEN, 32'h0, "ien");
      rc(IDX_LSR, 32'h20, "lsr");
      wr(IDX_LCTL, 8'h80);
      rc(IDX_DATA, {24'h0, DIV_RST[7:0]}, "div_lo");
      test_done();
   end
endmodule : uib_core_tb
